// [rtl/cme_pkg.sv]
// Constants, field layouts and carrier types of the client mux block.
// Assumes one 10 MHz clock domain shared by the host lanes and the media framer.
package cme_pkg;
    // Widths and counts
    localparam int DATA_W = 32;
    localparam int CP_MAX = 4;
    localparam int SLOT_W = 2;
    localparam int CNT_W  = 3;
    localparam int CODE_W = 8;
    localparam int IRQ_W  = 3;
    localparam int ADDR_W = 8;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] ADDR_CTRL  = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_CPCNT = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_TXREP = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_RXREP = 8'h0c;
    localparam logic [ADDR_W-1:0] ADDR_MCODE = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_HCODE = 8'h14;
    localparam logic [ADDR_W-1:0] ADDR_STAT  = 8'h18;
    localparam logic [ADDR_W-1:0] ADDR_CAP   = 8'h1c;
    localparam logic [ADDR_W-1:0] ADDR_ISTAT = 8'h20;
    localparam logic [ADDR_W-1:0] ADDR_IMASK = 8'h24;

    // Control field positions
    localparam int CTRL_NP_EN    = 0;
    localparam int CTRL_FORCE_SQ = 1;
    localparam int CTRL_AS_OFF   = 2;

    // Status field positions
    localparam int STAT_OVI_LSB = 0;
    localparam int STAT_SQ_LSB  = 4;
    localparam int STAT_LOS     = 8;
    localparam int STAT_CP_LSB  = 9;

    // Interrupt event positions
    localparam int IRQ_LOS    = 0;
    localparam int IRQ_FAIL   = 1;
    localparam int IRQ_STRUCT = 2;

    // Reset values
    localparam logic [CNT_W-1:0]  CPCNT_RST = 3'h1;
    localparam logic [CODE_W-1:0] CODE_RST  = 8'h00;
    localparam logic [2:0]        CAP_VAL   = 3'h7;

    // Replacement pattern seeds, combined with the interface code
    localparam logic [DATA_W-1:0] TX_REP_SEED = 32'h5a5a_0000;
    localparam logic [DATA_W-1:0] RX_REP_SEED = 32'h00a5_a500;

    // One word of the network signal with its slot marking
    typedef struct packed {
        logic              sof;
        logic              stuff;
        logic [SLOT_W-1:0] slot;
        logic [DATA_W-1:0] data;
    } cme_netw_s;

    // State of the top module apart from the reset synchroniser
    typedef struct packed {
        logic                          ack;
        logic [DATA_W-1:0]             prdata;
        logic                          pslverr;
        logic [2:0]                    ctrl;
        logic [CNT_W-1:0]              cp_cnt;
        logic [CNT_W-1:0]              cp_req;
        logic [CP_MAX-1:0]             txrep;
        logic [CP_MAX-1:0]             rxrep;
        logic [CODE_W-1:0]             mcode;
        logic [CODE_W-1:0]             hcode;
        logic [IRQ_W-1:0]              istat;
        logic [IRQ_W-1:0]              imask;
        logic [SLOT_W-1:0]             tx_slot;
        cme_netw_s                     ntx;
        logic                          ntx_valid;
        logic [SLOT_W-1:0]             rx_slot;
        logic [CP_MAX-1:0][DATA_W-1:0] hrx_data;
        logic [CP_MAX-1:0]             hrx_valid;
        logic [CP_MAX-1:0]             hrx_sq;
        logic [CP_MAX-1:0]             ovi;
        logic                          los_m;
        logic                          los_s;
        logic                          los_prev;
        logic [CP_MAX-1:0]             fail_prev;
    } cme_state_s;
endpackage

// [rtl/cme_top.sv]
// Client encapsulation data plane: N:1 / 1:1 mapping, replacement and squelch.
// Assumes host lanes and media framer run on clock; only the loss-of-signal pin is asynchronous.
//
// The implementer's own choices: register access over APB and the placing of the registers.
`timescale 1ns/100ps

// Function
// - Several host signals go into the network payload in one fixed slot order set by the structure.
// - With one connection point the single host signal fills every payload slot.
// - Empty slots are filled with stuff words so host and network rates may differ.
// - Once provisioned the network output runs every cycle regardless of host presence.
// - A structure change takes effect only at a slot-cycle boundary and leaves untouched lanes running.
// - An enabled Tx replacement puts a generated word into that connection point instead of host data.
// - Tx replacement words are formatted from the media interface code.
// - An enabled Rx replacement drives a generated stream built from the host interface code.
// - Lanes carrying an Rx replacement show their output-valid indicator set.
// - Host-side defects never squelch the Tx network output.
// - A forced squelch from software still silences the Tx network output.
// - Rx host outputs squelch automatically on network loss of signal or on a host path failure.
// - Rx auto-squelch is on by default, can be turned off, and a capability bit advertises that.
// - Rx replacement wins over any squelch condition.
// - Host lane i always feeds connection point i; there is no routing.
// - All host lanes share one word width and slot rate.
module cme_top
    import cme_pkg::*;
(
    input  wire logic                          clock,
    input  wire logic                          rstn,
    input  wire logic [ADDR_W-1:0]             paddr,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [DATA_W-1:0]             pwdata,
    input  wire logic [3:0]                    pstrb,
    output logic      [DATA_W-1:0]             prdata,
    output logic                               pready,
    output logic                               pslverr,
    input  wire logic [CP_MAX-1:0][DATA_W-1:0] host_tx_data,
    input  wire logic [CP_MAX-1:0]             host_tx_valid,
    output logic      [CP_MAX-1:0]             host_tx_ready,
    output cme_netw_s                          net_tx,
    output logic                               net_tx_valid,
    input  wire cme_netw_s                     net_rx,
    input  wire logic                          net_rx_valid,
    input  wire logic                          net_los_pin,
    input  wire logic [CP_MAX-1:0]             host_rx_fail,
    output logic      [CP_MAX-1:0][DATA_W-1:0] host_rx_data,
    output logic      [CP_MAX-1:0]             host_rx_valid,
    output logic      [CP_MAX-1:0]             host_rx_squelch,
    output logic      [CP_MAX-1:0]             rx_output_valid_indicator,
    output logic                               rx_autosquelch_off_capable,
    output logic                               irq
);

    cme_state_s        s_reg;
    cme_state_s        s_next;
    logic [1:0]        rst_q;
    logic              rst_n_i;
    logic [DATA_W-1:0] bmask;
    logic              acc;
    logic              wr_go;
    logic              mapped;
    logic              rd_only;
    logic [DATA_W-1:0] rd_val;
    logic [CNT_W-1:0]  slot_inc;
    logic              tx_wrap;
    logic [SLOT_W-1:0] rx_idx;
    logic [CNT_W-1:0]  rx_inc;
    logic [CNT_W-1:0]  wr_cp;
    logic [IRQ_W-1:0]  ev;
    logic              sq_cond;
    logic              word_here;
    logic [DATA_W-1:0] tx_rep_word;
    logic [DATA_W-1:0] rx_rep_word;

    // Merge written bytes over an old value
    function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old_v,
                                                input logic [DATA_W-1:0] new_v,
                                                input logic [DATA_W-1:0] m);
        merge = (old_v & ~m) | (new_v & m);
    endfunction

    // Reset release through two flops
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rst_q <= 2'h0;
        end else begin
            rst_q <= {rst_q[0], 1'b1};
        end
    end
    assign rst_n_i = rst_q[1];

    // Byte-lane mask from the strobes
    always_comb begin
        for (int b = 0; b < 4; b++) begin
            bmask[b*8 +: 8] = {8{pstrb[b]}};
        end
    end

    // Replacement words follow the selected interface codes
    assign tx_rep_word = TX_REP_SEED ^ {4{s_reg.mcode}};
    assign rx_rep_word = RX_REP_SEED ^ {4{s_reg.hcode}};

    // Bus decode
    assign acc     = psel & penable;
    assign wr_go   = acc & pwrite & s_reg.ack;
    assign mapped  = (paddr <= ADDR_IMASK) && (paddr[1:0] == 2'h0);
    assign rd_only = (paddr == ADDR_STAT) || (paddr == ADDR_CAP);
    assign wr_cp   = (pwdata[CNT_W-1:0] == 3'h0) ? 3'h1 :
                     (pwdata[CNT_W-1:0] > CNT_W'(CP_MAX)) ? CNT_W'(CP_MAX) : pwdata[CNT_W-1:0];

    // Read multiplexer
    always_comb begin
        rd_val = '0;
        unique case (paddr)
            ADDR_CTRL:  rd_val[2:0]        = s_reg.ctrl;
            ADDR_CPCNT: rd_val[CNT_W-1:0]  = s_reg.cp_req;
            ADDR_TXREP: rd_val[CP_MAX-1:0] = s_reg.txrep;
            ADDR_RXREP: rd_val[CP_MAX-1:0] = s_reg.rxrep;
            ADDR_MCODE: rd_val[CODE_W-1:0] = s_reg.mcode;
            ADDR_HCODE: rd_val[CODE_W-1:0] = s_reg.hcode;
            ADDR_STAT: begin
                rd_val[STAT_OVI_LSB +: CP_MAX] = s_reg.ovi;
                rd_val[STAT_SQ_LSB +: CP_MAX]  = s_reg.hrx_sq;
                rd_val[STAT_LOS]               = s_reg.los_s;
                rd_val[STAT_CP_LSB +: CNT_W]   = s_reg.cp_cnt;
            end
            ADDR_CAP:   rd_val[2:0]        = CAP_VAL;
            ADDR_ISTAT: rd_val[IRQ_W-1:0]  = s_reg.istat;
            ADDR_IMASK: rd_val[IRQ_W-1:0]  = s_reg.imask;
            default:    rd_val             = '0;
        endcase
    end

    // Slot sequencing helpers
    assign slot_inc = {1'b0, s_reg.tx_slot} + CNT_W'(1);
    assign tx_wrap  = slot_inc >= s_reg.cp_cnt;
    assign rx_idx   = net_rx.sof ? SLOT_W'(0) : s_reg.rx_slot;
    assign rx_inc   = {1'b0, rx_idx} + CNT_W'(1);

    // Host lanes are taken only in their own slot, or always when replaced
    always_comb begin
        for (int i = 0; i < CP_MAX; i++) begin
            host_tx_ready[i] = s_reg.txrep[i] |
                               (s_reg.ctrl[CTRL_NP_EN] && (s_reg.tx_slot == SLOT_W'(i))
                                && (CNT_W'(i) < s_reg.cp_cnt));
        end
    end

    // Next state
    always_comb begin
        s_next       = s_reg;
        ev           = '0;
        sq_cond      = 1'b0;
        word_here    = 1'b0;

        // Bus access: read data captured in the first access cycle, write data and answer in the second
        s_next.ack = acc & ~s_reg.ack;
        if (acc && !s_reg.ack) begin
            s_next.prdata  = pwrite ? '0 : rd_val;
            s_next.pslverr = ~mapped;
        end
        if (wr_go && mapped && !rd_only) begin
            unique case (paddr)
                ADDR_CTRL:  s_next.ctrl  = 3'(merge({29'h0, s_reg.ctrl}, pwdata, bmask));
                ADDR_CPCNT: begin
                    if (pstrb[0]) begin
                        s_next.cp_req = wr_cp;
                    end
                end
                ADDR_TXREP: s_next.txrep = CP_MAX'(merge({28'h0, s_reg.txrep}, pwdata, bmask));
                ADDR_RXREP: s_next.rxrep = CP_MAX'(merge({28'h0, s_reg.rxrep}, pwdata, bmask));
                ADDR_MCODE: s_next.mcode = CODE_W'(merge({24'h0, s_reg.mcode}, pwdata, bmask));
                ADDR_HCODE: s_next.hcode = CODE_W'(merge({24'h0, s_reg.hcode}, pwdata, bmask));
                ADDR_IMASK: s_next.imask = IRQ_W'(merge({29'h0, s_reg.imask}, pwdata, bmask));
                default:    s_next.imask = s_reg.imask;
            endcase
        end

        // Tx slot counter runs freely so the structure is always paced
        s_next.tx_slot = tx_wrap ? SLOT_W'(0) : slot_inc[SLOT_W-1:0];
        if (tx_wrap && (s_reg.cp_req != s_reg.cp_cnt)) begin
            s_next.cp_cnt   = s_reg.cp_req;
            ev[IRQ_STRUCT] = 1'b1;
        end

        // Tx network word: replacement, host data or stuffing
        s_next.ntx.slot  = s_reg.tx_slot;
        s_next.ntx.sof   = (s_reg.tx_slot == SLOT_W'(0));
        s_next.ntx.stuff = 1'b0;
        if (s_reg.txrep[s_reg.tx_slot]) begin
            s_next.ntx.data = tx_rep_word;
        end else if (host_tx_valid[s_reg.tx_slot]) begin
            s_next.ntx.data = host_tx_data[s_reg.tx_slot];
        end else begin
            s_next.ntx.data  = '0;
            s_next.ntx.stuff = 1'b1;
        end
        // Only the enable and a forced squelch gate the output; host defects are ignored here
        s_next.ntx_valid = s_reg.ctrl[CTRL_NP_EN] & ~s_reg.ctrl[CTRL_FORCE_SQ];

        // Rx demap slot tracking, resynchronised on start of frame
        if (net_rx_valid) begin
            s_next.rx_slot = (rx_inc >= s_reg.cp_cnt) ? SLOT_W'(0) : rx_inc[SLOT_W-1:0];
        end

        // Loss of signal through two flops, then edge detect
        s_next.los_m     = net_los_pin;
        s_next.los_s     = s_reg.los_m;
        s_next.los_prev  = s_reg.los_s;
        s_next.fail_prev = host_rx_fail;
        ev[IRQ_LOS]      = s_reg.los_s & ~s_reg.los_prev;
        ev[IRQ_FAIL]     = |(host_rx_fail & ~s_reg.fail_prev);

        // Per-lane Rx output selection
        for (int i = 0; i < CP_MAX; i++) begin
            sq_cond   = ~s_reg.ctrl[CTRL_AS_OFF] & (s_reg.los_s | host_rx_fail[i]);
            word_here = net_rx_valid && (rx_idx == SLOT_W'(i)) && (CNT_W'(i) < s_reg.cp_cnt);
            s_next.hrx_valid[i] = 1'b0;
            if (s_reg.rxrep[i]) begin
                // Replacement beats any squelch condition
                s_next.hrx_sq[i] = 1'b0;
                s_next.ovi[i]    = 1'b1;
                if (s_reg.tx_slot == SLOT_W'(i)) begin
                    s_next.hrx_data[i]  = rx_rep_word;
                    s_next.hrx_valid[i] = 1'b1;
                end
            end else if (sq_cond || (CNT_W'(i) >= s_reg.cp_cnt)) begin
                s_next.hrx_sq[i]   = 1'b1;
                s_next.ovi[i]      = 1'b0;
                s_next.hrx_data[i] = '0;
            end else begin
                s_next.hrx_sq[i] = 1'b0;
                s_next.ovi[i]    = ~s_reg.los_s & ~host_rx_fail[i];
                if (word_here && !net_rx.stuff) begin
                    s_next.hrx_data[i]  = net_rx.data;
                    s_next.hrx_valid[i] = 1'b1;
                end
            end
        end

        // Sticky events: a new event wins over a write-one clear
        s_next.istat = s_reg.istat;
        if (wr_go && (paddr == ADDR_ISTAT) && pstrb[0]) begin
            s_next.istat = s_reg.istat & ~pwdata[IRQ_W-1:0];
        end
        s_next.istat = s_next.istat | ev;
    end

    // State register
    always_ff @(posedge clock or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_reg        <= '0;
            s_reg.cp_cnt <= CPCNT_RST;
            s_reg.cp_req <= CPCNT_RST;
            s_reg.mcode  <= CODE_RST;
            s_reg.hcode  <= CODE_RST;
            s_reg.hrx_sq <= '1;
        end else begin
            s_reg <= s_next;
        end
    end

    // Outputs
    assign prdata                     = s_reg.prdata;
    assign pready                     = s_reg.ack;
    assign pslverr                    = s_reg.ack & s_reg.pslverr;
    assign net_tx                     = s_reg.ntx;
    assign net_tx_valid               = s_reg.ntx_valid;
    assign host_rx_data               = s_reg.hrx_data;
    assign host_rx_valid              = s_reg.hrx_valid;
    assign host_rx_squelch            = s_reg.hrx_sq;
    assign rx_output_valid_indicator  = s_reg.ovi;
    assign rx_autosquelch_off_capable = CAP_VAL[0];
    assign irq                        = |(s_reg.istat & s_reg.imask);

endmodule

// [test/cme_media_model.sv]
// Media line model feeding the receive side of the block.
// Assumes the same clock as the block and the active lane count.
`timescale 1ns/100ps
module cme_media_model
    import cme_pkg::*;
(
    input  wire logic             clock,
    input  wire logic             run,
    input  wire logic             stuff_on,
    input  wire logic [CNT_W-1:0] n,
    output cme_netw_s             net_rx,
    output logic                  net_rx_valid
);
    logic [CNT_W-1:0]  k;
    logic [DATA_W-1:0] w;
    logic              st;

    initial begin
        k = '0;
        w = 32'h1234_5677;
        net_rx = '0;
        net_rx_valid = 1'b0;
    end
    assign st = stuff_on && k == '0;

    // Words in lane order from each frame start; stuff only at a frame start
    always @(posedge clock) begin
        if (run) begin
            net_rx_valid <= 1'b1;
            net_rx.sof <= k == '0;
            net_rx.stuff <= st;
            net_rx.slot <= k[SLOT_W-1:0];
            net_rx.data <= w;
            if (!st) begin
                k <= (k + 3'h1 >= n) ? 3'h0 : k + 3'h1;
                w <= w * 32'h0019_660d + 32'h3c6e_f35f;
            end
        end else begin
            net_rx_valid <= 1'b0;
            net_rx.data <= ~net_rx.data;                  // Released line inverts the held data word every cycle
        end
    end
endmodule

// [test/cme_monitor.sv]
// Port checker for the client mux block.
// Assumes it is bound to cme_top and shares its clock and reset.
`timescale 1ns/100ps
module cme_monitor
    import cme_pkg::*;
(
    input wire logic                          clock,
    input wire logic                          rstn,
    input wire logic [ADDR_W-1:0]             paddr,
    input wire logic                          psel,
    input wire logic                          penable,
    input wire logic                          pwrite,
    input wire logic [DATA_W-1:0]             pwdata,
    input wire logic                          pready,
    input wire logic [CP_MAX-1:0][DATA_W-1:0] host_tx_data,
    input wire logic [CP_MAX-1:0]             host_tx_valid,
    input wire logic [CP_MAX-1:0]             host_tx_ready,
    input wire cme_netw_s                     net_tx,
    input wire logic                          net_tx_valid,
    input wire cme_netw_s                     net_rx,
    input wire logic                          net_rx_valid,
    input wire logic [CP_MAX-1:0][DATA_W-1:0] host_rx_data,
    input wire logic [CP_MAX-1:0]             host_rx_valid,
    input wire logic [CP_MAX-1:0]             host_rx_squelch,
    input wire logic [CP_MAX-1:0]             rx_output_valid_indicator,
    input wire logic                          rx_autosquelch_off_capable
);
    logic [1:0] up;
    logic       tv;
    logic       ok;

    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);

    // Waits out the synchronised reset release, then tracks the written tx enable gated by forced squelch
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            up <= 2'h0;
            tv <= 1'b0;
        end else begin
            if (up != 2'h3) up <= up + 2'h1;
            if (psel && penable && pready && pwrite && paddr == ADDR_CTRL) tv <= pwdata[0] & ~pwdata[1];
        end
    end
    assign ok = up == 2'h3;

    AST_CAP: assert property (ok |-> rx_autosquelch_off_capable)
        else $error("capability bit low");
    AST_SQ_VALID: assert property ((host_rx_squelch & host_rx_valid) == 4'h0)
        else $error("squelched lane carries valid");
    AST_SQ_OVI: assert property ((host_rx_squelch & rx_output_valid_indicator) == 4'h0)
        else $error("squelched lane shows output valid");
    AST_TX_SQ: assert property (ok && $changed(tv) |-> ##[1:3] net_tx_valid == tv)
        else $error("tx valid does not follow enable and force");
    AST_TX_HOLD: assert property (ok && $changed(net_tx_valid) |-> net_tx_valid == tv)
        else $error("tx valid moved without software");
    AST_TX_MAP: assert property (ok && host_tx_ready[1] && host_tx_valid[1] |=>
        net_tx.slot == 2'h1 && !net_tx.stuff && net_tx.data == $past(host_tx_data[1]))
        else $error("lane 1 word not in slot 1");
    AST_SOF: assert property (ok |-> net_tx.sof == (net_tx.slot == 2'h0) &&
        (net_tx.sof || net_tx.slot == $past(net_tx.slot) + 2'h1))
        else $error("slot out of order");
    AST_RX_MAP: assert property (ok && net_rx_valid && net_rx.sof && !net_rx.stuff |=>
        host_rx_squelch[0] || (host_rx_valid[0] && host_rx_data[0] == $past(net_rx.data)))
        else $error("frame start word not on lane 0");
    AST_STUFF: assert property (ok && net_rx_valid && net_rx.stuff |=> host_rx_valid[2:0] == 3'h0)
        else $error("stuff word delivered");
endmodule

bind cme_top cme_monitor cme_monitor_i (
    .clock(clock), .rstn(rstn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .pready(pready), .host_tx_data(host_tx_data), .host_tx_valid(host_tx_valid),
    .host_tx_ready(host_tx_ready), .net_tx(net_tx), .net_tx_valid(net_tx_valid), .net_rx(net_rx),
    .net_rx_valid(net_rx_valid), .host_rx_data(host_rx_data), .host_rx_valid(host_rx_valid),
    .host_rx_squelch(host_rx_squelch), .rx_output_valid_indicator(rx_output_valid_indicator),
    .rx_autosquelch_off_capable(rx_autosquelch_off_capable));

// [test/test_cme_top.sv]
// Self-checking bench for the client mux block.
// Assumes cme_top with the media model on its receive side.
`timescale 1ns/100ps
module test_cme_top
    import cme_pkg::*;
;
    logic clock, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, irq, net_tx_valid;
    logic [ADDR_W-1:0] paddr = '0;
    logic [DATA_W-1:0] pwdata = '0, prdata, rd, ew;
    logic [3:0] pstrb = 4'hf, host_tx_valid = '0, host_rx_fail = '0, trep = '0, pv;
    logic [CP_MAX-1:0][DATA_W-1:0] host_tx_data = '0, host_rx_data, pd;
    logic [CP_MAX-1:0] host_tx_ready, host_rx_valid, host_rx_squelch, rx_output_valid_indicator;
    logic net_los_pin = 1'b0, net_rx_valid, rx_autosquelch_off_capable, er, ev, ctx = 0, crx = 0, run = 0, stuff_on = 0;
    cme_netw_s net_tx, net_rx;
    logic [1:0] s;
    logic [7:0] mc, hc;
    int seed = 4843, cn = 1, cyc = 0, failures = 0, n_checks = 0, ps = 0, el = 0;
    logic [DATA_W-1:0] rv [10] = '{32'h0, 32'h1, 32'h0, 32'h0, 32'h0, 32'h0, 32'h2e1, 32'h7, 32'h0, 32'h0};

    cme_top cme_top_i (.*);
    cme_media_model cme_media_model_i (.clock(clock), .run(run), .stuff_on(stuff_on), .n(cn[CNT_W-1:0]),
                                       .net_rx(net_rx), .net_rx_valid(net_rx_valid));

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    task automatic print_verdict;
        if (failures == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input logic [DATA_W-1:0] g, input logic [DATA_W-1:0] e);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    // One APB transfer; waits for pready, then releases the bus
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) begin
            @(posedge clock);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        apb(1'b0, a, '0);
        chk(rd, e);
    endtask

    // Random host traffic and stuffing, plus the run limit
    always @(posedge clock) begin
        for (int i = 0; i < CP_MAX; i++) host_tx_data[i] <= $random(seed);
        host_tx_valid <= 4'($random(seed));
        stuff_on <= ($random(seed) & 7) == 0;
        cyc++;
        if (cyc == 5000) begin
            failures++;
            print_verdict();
        end
    end

    // Transmit slots: order, payload, replacement and stuffing
    always @(posedge clock) begin
        s = net_tx.slot;
        if (ctx) begin
            chk(s, ps + 1 >= cn ? 0 : ps + 1);
            chk(net_tx.data, trep[s] ? TX_REP_SEED ^ {4{mc}} : pv[s] ? pd[s] : 0);
            chk(net_tx.stuff, !trep[s] && !pv[s]);
        end
        ps = s;
        pd = host_tx_data;
        pv = host_tx_valid;
    end

    // Receive demapping: each word lands on its lane one cycle later
    always @(posedge clock) begin
        if (crx && ev) chk(host_rx_data[el], ew);
        if (crx && ev) chk(host_rx_valid[el], 1);
        ev = net_rx_valid && !net_rx.stuff;
        ew = net_rx.data;
        if (net_rx_valid) el = net_rx.sof ? 0 : (el + 1 >= cn ? 0 : el + 1);
    end

    initial begin
        repeat (20) @(posedge clock);
        rstn <= 1'b1;
        repeat (3) @(posedge clock);
        for (int i = 0; i < 10; i++) rdc(8'(i * 4), rv[i]);
        apb(1'b0, 8'h28, '0);
        chk(er, 1);
        chk(rx_autosquelch_off_capable, 1);
        wr(ADDR_CPCNT, 32'h0);
        rdc(ADDR_CPCNT, 32'h1);
        wr(ADDR_CPCNT, 32'h7);
        rdc(ADDR_CPCNT, 32'h4);
        cn = 4;
        mc = 8'($random(seed));
        hc = 8'($random(seed));
        wr(ADDR_MCODE, {24'h0, mc});
        wr(ADDR_HCODE, {24'h0, hc});
        wr(ADDR_CTRL, 32'h1);
        wr(ADDR_ISTAT, 32'h7);
        wr(ADDR_IMASK, 32'h7);
        chk(irq, 0);
        run <= 1'b1;
        repeat (8) @(posedge clock);
        ctx = 1;
        crx = 1;
        repeat (200) @(posedge clock);
        ctx = 0;
        trep = 4'h8;
        wr(ADDR_TXREP, 32'h8);
        repeat (3) @(posedge clock);
        ctx = 1;
        repeat (40) @(posedge clock);
        chk(host_tx_ready[3], 1);
        wr(ADDR_CTRL, 32'h3);
        repeat (3) @(posedge clock);
        chk(net_tx_valid, 0);
        wr(ADDR_CTRL, 32'h1);
        crx = 0;
        host_rx_fail <= 4'h2;
        repeat (4) @(posedge clock);
        chk(net_tx_valid, 1);
        chk(host_rx_squelch, 4'h2);
        chk(rx_output_valid_indicator, 4'hd);
        chk(irq, 1);
        host_rx_fail <= 4'h0;
        wr(ADDR_IMASK, 32'h0);
        chk(irq, 0);
        wr(ADDR_ISTAT, 32'h7);
        net_los_pin <= 1'b1;
        repeat (6) @(posedge clock);
        chk(host_rx_squelch, 4'hf);
        wr(ADDR_CTRL, 32'h5);
        repeat (3) @(posedge clock);
        chk(host_rx_squelch, 4'h0);
        wr(ADDR_CTRL, 32'h1);
        wr(ADDR_RXREP, 32'h8);
        repeat (8) @(posedge clock);
        chk(host_rx_squelch, 4'h7);
        chk(rx_output_valid_indicator, 4'h8);
        for (int t = 0; t < 20 && host_rx_valid[3] !== 1'b1; t++) @(posedge clock);
        chk(host_rx_data[3], RX_REP_SEED ^ {4{hc}});
        net_los_pin <= 1'b0;
        wr(ADDR_RXREP, 32'h0);
        repeat (6) @(posedge clock);
        wr(ADDR_ISTAT, 32'h7);
        wr(ADDR_IMASK, 32'h7);
        ctx = 0;
        cn = 2;
        wr(ADDR_CPCNT, 32'h2);
        repeat (8) @(posedge clock);
        rdc(ADDR_ISTAT, 32'h4);
        chk(net_tx_valid, 1);
        chk(host_rx_squelch, 4'hc);
        ctx = 1;
        crx = 1;
        repeat (100) @(posedge clock);
        ctx = 0;
        crx = 0;
        cn = 1;
        wr(ADDR_CPCNT, 32'h1);
        repeat (8) @(posedge clock);
        ctx = 1;
        crx = 1;
        repeat (60) @(posedge clock);
        print_verdict();
    end
endmodule
